//--- rtl/wcku_counter.sv
// prescaler and main down-counter of the watchdog
// assumes run, reload and settings come from the control logic in the same clock domain
`timescale 1ns/1ns
`default_nettype none

module wcku_counter (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic reload,
    input wire logic pmode,
    input wire logic [3:0] divdn,
    input wire logic [15:0] period,
    output logic [15:0] pcnt_ff,
    output logic [15:0] cnt_ff,
    output logic expire_ff
);
    import wcku_pkg::*;

    typedef struct packed {
        logic [15:0] pcnt;
        logic [15:0] cnt;
        logic expire;
    } wcku_cnt_t;

    wcku_cnt_t st_ff;
    wcku_cnt_t nxt_st;
    logic [15:0] reload_val;

    // =====================================================================
    // prescaler reload value: raw code in direct mode, decoded mask otherwise
    always_comb begin
        if (pmode) begin
            reload_val = 16'hFFFF >> (4'hF - divdn);
        end else begin
            reload_val = {12'h000, divdn};
        end
    end

    // reload beats run so a service or enable always starts a fresh period
    always_comb begin
        nxt_st = st_ff;
        nxt_st.expire = 1'b0;
        if (reload) begin
            nxt_st.pcnt = reload_val;
            nxt_st.cnt = period;
        end else if (run) begin
            if (st_ff.pcnt == 16'h0000) begin
                nxt_st.pcnt = reload_val;
                if (st_ff.cnt == 16'h0000) begin
                    nxt_st.expire = 1'b1;
                    nxt_st.cnt = period;
                end else begin
                    nxt_st.cnt = st_ff.cnt - 16'h0001;
                end
            end else begin
                nxt_st.pcnt = st_ff.pcnt - 16'h0001;
            end
        end
    end

    // state register; counters come up at all ones so a stray run is slow
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '{pcnt: RST_PERIOD, cnt: RST_PERIOD, expire: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign pcnt_ff = st_ff.pcnt;
    assign cnt_ff = st_ff.cnt;
    assign expire_ff = st_ff.expire;

    property p_pre_reload;
        @(posedge ref_clk) disable iff (!rst_n)
        (run && !reload && st_ff.pcnt == 16'h0000) |=> (st_ff.pcnt == $past(reload_val));
    endproperty
    a_pre_reload: assert property (p_pre_reload)
        else $error("prescaler did not reload with the selected value");

endmodule // wcku_counter

`default_nettype wire

//--- rtl/wcku_pkg.sv
// constants and types shared by the watchdog control/key unit
// assumes a single 50 MHz clock and an AXI4-Lite register port with 32-bit data

package wcku_pkg;

    // =====================================================================
    // register map (byte addresses on the AXI4-Lite port)
    localparam logic [7:0] OFS_CTRL_ONE = 8'h00;
    localparam logic [7:0] OFS_CTRL_TWO = 8'h04;
    localparam logic [7:0] OFS_PERIOD = 8'h08;
    localparam logic [7:0] OFS_COUNT = 8'h0C;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h14;

    // =====================================================================
    // field positions
    localparam int FLAG_BIT = 15;
    localparam int EN_BIT = 14;
    localparam int RSVD_BIT = 13;
    localparam int PMODE_BIT = 12;
    localparam int KEY_MSB = 11;
    localparam int KEY_LSB = 0;
    localparam int DIVDN_MSB = 3;
    localparam int DIVDN_LSB = 0;
    localparam int PCNT_MSB = 7;
    localparam int PCNT_LSB = 4;
    localparam int IRQ_TIMEOUT = 0;
    localparam int IRQ_SERVICE = 1;

    // =====================================================================
    // reset values and key words
    localparam logic [3:0] RST_DIVDN = 4'h0;
    localparam logic RST_PMODE = 1'b1;
    localparam logic [11:0] RST_KEY = 12'h000;
    localparam logic [15:0] RST_PERIOD = 16'hFFFF;
    localparam logic [1:0] RST_IRQ_MASK = 2'h0;
    localparam logic [11:0] KEY_FIRST = 12'h5C6;
    localparam logic [11:0] KEY_SECOND = 12'hA7E;

    // =====================================================================
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // key sequence state
    typedef enum logic {
        KEY_IDLE = 1'b0,
        KEY_ARMED = 1'b1
    } wcku_key_t;

endpackage

//--- rtl/wcku_top.sv
// watchdog control/key unit: second control register, key check, interrupts
// assumes an AXI4-Lite master on ref_clk and an active-low asynchronous reset
`timescale 1ns/1ns
`default_nettype none

module wcku_top (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq,
    output logic wd_timeout
);
    import wcku_pkg::*;

    typedef struct packed {
        logic awready;
        logic wready;
        logic aw_hold;
        logic [7:0] aw_addr;
        logic w_hold;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [3:0] divdn;
        logic flag;
        logic en;
        logic pmode;
        logic [11:0] key;
        wcku_key_t kstate;
        logic [15:0] period;
        logic [1:0] irq_stat;
        logic [1:0] irq_mask;
        logic irq;
        logic timeout;
    } wcku_state_t;

    localparam wcku_state_t RST_STATE = '{
        divdn: RST_DIVDN,
        pmode: RST_PMODE,
        key: RST_KEY,
        kstate: KEY_IDLE,
        period: RST_PERIOD,
        irq_mask: RST_IRQ_MASK,
        default: '0
    };

    wcku_state_t st_ff;
    wcku_state_t nxt_st;

    logic [15:0] pcnt;
    logic [15:0] cnt;
    logic expire;

    logic wr_fire;
    logic wr_ctl2;
    logic [15:0] ctl2_now;
    logic [15:0] ctl2_new;
    logic key_first;
    logic key_second;
    logic bad_key;
    logic service;
    logic en_rise;
    logic timeout_evt;
    logic flag_w1c;
    logic [31:0] one_merged;
    logic [31:0] two_merged;
    logic [31:0] per_merged;

    // =====================================================================
    // counters; they only run while enabled
    wcku_counter u_counter (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .run(st_ff.en),
        .reload(service | en_rise),
        // mode and code as written this cycle, so an enabling write starts in its own mode
        .pmode(nxt_st.pmode),
        .divdn(nxt_st.divdn),
        .period(st_ff.period),
        .pcnt_ff(pcnt),
        .cnt_ff(cnt),
        .expire_ff(expire)
    );

    // =====================================================================
    // helpers: byte-lane merge and read mux
    function automatic logic [31:0] merge_word(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return res;
    endfunction

    // the 16-bit prescaler stays hidden in indirect mode
    function automatic logic [31:0] read_mux(input wcku_state_t s, input logic [7:0] addr,
                                             input logic [15:0] p, input logic [15:0] c);
        logic [31:0] v;
        v = 32'h0000_0000;
        unique case (addr)
            OFS_CTRL_ONE: begin
                v[DIVDN_MSB:DIVDN_LSB] = s.divdn;
                v[PCNT_MSB:PCNT_LSB] = s.pmode ? 4'h0 : p[3:0];
            end
            OFS_CTRL_TWO: begin
                v[FLAG_BIT] = s.flag;
                v[EN_BIT] = s.en;
                v[RSVD_BIT] = 1'b0;
                v[PMODE_BIT] = s.pmode;
                v[KEY_MSB:KEY_LSB] = s.key;
            end
            OFS_PERIOD: v[15:0] = s.period;
            OFS_COUNT: v[15:0] = c;
            OFS_IRQ_STAT: v[1:0] = s.irq_stat;
            OFS_IRQ_MASK: v[1:0] = s.irq_mask;
            default: v = 32'h0000_0000;
        endcase
        return v;
    endfunction

    function automatic logic addr_ok(input logic [7:0] addr);
        return addr == OFS_CTRL_ONE || addr == OFS_CTRL_TWO || addr == OFS_PERIOD ||
               addr == OFS_COUNT || addr == OFS_IRQ_STAT || addr == OFS_IRQ_MASK;
    endfunction

    // =====================================================================
    // write-side decode; every write to the second control register is a key write
    always_comb begin
        wr_fire = st_ff.aw_hold & st_ff.w_hold & ~st_ff.bvalid;
        wr_ctl2 = wr_fire & (st_ff.aw_addr == OFS_CTRL_TWO);
        ctl2_now = {st_ff.flag, st_ff.en, 1'b0, st_ff.pmode, st_ff.key};
        // merged words go through variables: a select straight on a call is not legal
        one_merged = merge_word({28'h0000000, st_ff.divdn}, st_ff.w_data, st_ff.w_strb);
        two_merged = merge_word({16'h0000, ctl2_now}, st_ff.w_data, st_ff.w_strb);
        per_merged = merge_word({16'h0000, st_ff.period}, st_ff.w_data, st_ff.w_strb);
        ctl2_new = two_merged[15:0];
        key_first = ctl2_new[KEY_MSB:KEY_LSB] == KEY_FIRST;
        key_second = (ctl2_new[KEY_MSB:KEY_LSB] == KEY_SECOND) && (st_ff.kstate == KEY_ARMED);
        bad_key = wr_ctl2 & ~key_first & ~key_second;
        service = wr_ctl2 & key_second;
        en_rise = wr_ctl2 & ctl2_new[EN_BIT] & ~st_ff.en;
        flag_w1c = wr_ctl2 & ctl2_new[FLAG_BIT];
        timeout_evt = bad_key | (expire & st_ff.en);
    end

    // =====================================================================
    // next-state logic for bus, control register and interrupts
    always_comb begin
        nxt_st = st_ff;
        nxt_st.timeout = timeout_evt;
        // address and data are caught independently, in either order
        if (s_axi_awvalid && st_ff.awready) begin
            nxt_st.aw_hold = 1'b1;
            nxt_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_ff.wready) begin
            nxt_st.w_hold = 1'b1;
            nxt_st.w_data = s_axi_wdata;
            nxt_st.w_strb = s_axi_wstrb;
        end
        if (st_ff.bvalid && s_axi_bready) begin
            nxt_st.bvalid = 1'b0;
        end
        if (wr_fire) begin
            nxt_st.aw_hold = 1'b0;
            nxt_st.w_hold = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp = addr_ok(st_ff.aw_addr) ? RESP_OKAY : RESP_SLVERR;
            unique case (st_ff.aw_addr)
                OFS_CTRL_ONE: begin
                    nxt_st.divdn = one_merged[DIVDN_MSB:DIVDN_LSB];
                end
                OFS_CTRL_TWO: begin
                    nxt_st.pmode = ctl2_new[PMODE_BIT];
                    nxt_st.key = ctl2_new[KEY_MSB:KEY_LSB];
                    // a first key arms; anything else, good pair or not, disarms
                    nxt_st.kstate = key_first ? KEY_ARMED : KEY_IDLE;
                end
                OFS_PERIOD: begin
                    nxt_st.period = per_merged[15:0];
                end
                OFS_IRQ_STAT: begin
                    if (st_ff.w_strb[0]) begin
                        nxt_st.irq_stat = st_ff.irq_stat & ~st_ff.w_data[1:0];
                    end
                end
                OFS_IRQ_MASK: begin
                    if (st_ff.w_strb[0]) begin
                        nxt_st.irq_mask = st_ff.w_data[1:0];
                    end
                end
                default: begin
                end
            endcase
        end
        // flag: clears first so a same-cycle time-out still wins
        if (flag_w1c || en_rise) begin
            nxt_st.flag = 1'b0;
        end
        if (en_rise) begin
            nxt_st.en = 1'b1; // writing 0 never disables
        end
        if (timeout_evt) begin
            nxt_st.flag = 1'b1;
            nxt_st.en = 1'b0;
        end
        // sticky events, set beats the write-one clear above
        if (timeout_evt) begin
            nxt_st.irq_stat[IRQ_TIMEOUT] = 1'b1;
        end
        if (service) begin
            nxt_st.irq_stat[IRQ_SERVICE] = 1'b1;
        end
        nxt_st.irq = |(nxt_st.irq_stat & nxt_st.irq_mask);
        // read channel: one outstanding read, data latched at acceptance
        if (st_ff.rvalid && s_axi_rready) begin
            nxt_st.rvalid = 1'b0;
        end
        if (s_axi_arvalid && st_ff.arready) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rdata = read_mux(st_ff, s_axi_araddr, pcnt, cnt);
            nxt_st.rresp = addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end
        nxt_st.awready = ~nxt_st.aw_hold & ~nxt_st.bvalid;
        nxt_st.wready = ~nxt_st.w_hold & ~nxt_st.bvalid;
        nxt_st.arready = ~nxt_st.rvalid;
    end

    // =====================================================================
    // state register
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= RST_STATE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // outputs straight from the state flops
    assign s_axi_awready = st_ff.awready;
    assign s_axi_wready = st_ff.wready;
    assign s_axi_bresp = st_ff.bresp;
    assign s_axi_bvalid = st_ff.bvalid;
    assign s_axi_arready = st_ff.arready;
    assign s_axi_rdata = st_ff.rdata;
    assign s_axi_rresp = st_ff.rresp;
    assign s_axi_rvalid = st_ff.rvalid;
    assign irq = st_ff.irq;
    assign wd_timeout = st_ff.timeout;

    // =====================================================================
    // assertions
    property p_flag_set;
        @(posedge ref_clk) disable iff (!rst_n)
        timeout_evt |=> st_ff.flag && wd_timeout;
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("time-out did not set the flag");

    property p_flag_clear;
        @(posedge ref_clk) disable iff (!rst_n)
        $fell(st_ff.flag) |-> $past(flag_w1c || en_rise);
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("flag cleared without cause");

    property p_stopped;
        @(posedge ref_clk) disable iff (!rst_n)
        (!st_ff.en && !service && !en_rise) |=> $stable(cnt) && !expire;
    endproperty
    a_stopped: assert property (p_stopped)
        else $error("counter moved while disabled");

    property p_route;
        @(posedge ref_clk) disable iff (!rst_n)
        (expire && st_ff.en) |=> wd_timeout ##1 !wd_timeout;
    endproperty
    a_route: assert property (p_route)
        else $error("expiry not routed to time-out");

    property p_en_hold;
        @(posedge ref_clk) disable iff (!rst_n)
        $fell(st_ff.en) |-> $past(timeout_evt);
    endproperty
    a_en_hold: assert property (p_en_hold)
        else $error("enable dropped without a time-out");

    property p_rsvd;
        @(posedge ref_clk) disable iff (!rst_n)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_CTRL_TWO)
            |=> !s_axi_rdata[RSVD_BIT];
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved bit read as one");

    property p_good_pair;
        @(posedge ref_clk) disable iff (!rst_n)
        service |=> !wd_timeout && st_ff.kstate == KEY_IDLE && cnt == $past(st_ff.period);
    endproperty
    a_good_pair: assert property (p_good_pair)
        else $error("valid key pair did not service");

    property p_bad_key;
        @(posedge ref_clk) disable iff (!rst_n)
        bad_key |=> wd_timeout && !st_ff.en && st_ff.irq_stat[IRQ_TIMEOUT];
    endproperty
    a_bad_key: assert property (p_bad_key)
        else $error("wrong key did not time out");

    property p_hidden_pcnt;
        @(posedge ref_clk) disable iff (!rst_n)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_CTRL_ONE && st_ff.pmode)
            |=> s_axi_rdata[PCNT_MSB:PCNT_LSB] == 4'h0;
    endproperty
    a_hidden_pcnt: assert property (p_hidden_pcnt)
        else $error("indirect prescaler leaked to software");

    property p_enable_clears;
        @(posedge ref_clk) disable iff (!rst_n)
        (en_rise && !bad_key) |=> st_ff.en && !st_ff.flag && !wd_timeout;
    endproperty
    a_enable_clears: assert property (p_enable_clears)
        else $error("enabling did not clear the flag");

endmodule // wcku_top

`default_nettype wire

//--- test/test_watchdog_control_key_unit.sv
// self-checking bench for the watchdog control/key unit
// assumes wcku_pkg and wcku_top are compiled first; only the AXI4-Lite port is driven
`timescale 1ns/1ns
`default_nettype none

module test_watchdog_control_key_unit;
    import wcku_pkg::*;

    // =====================================================================
    // clock, reset and port wiring
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq, wd_timeout;
    logic [1:0] bresp, rresp, bresp_q, rresp_q;
    logic [31:0] rdata, rdata_q, p1;
    int failures = 0;
    int checks_done = 0;
    int to_seen = 0;
    int base, c1, c2, c3, c4;

    typedef struct {
        logic [7:0] a;
        logic [31:0] d;
        logic [31:0] m;
        logic [31:0] e;
        logic [1:0] r;
    } wcku_row_t;

    // ordinary accesses: address, write data, read mask, expected read, response
    wcku_row_t rows [6] = '{
        '{OFS_PERIOD, 32'h0000_0003, 32'hFFFF_FFFF, 32'h0000_0003, RESP_OKAY},
        '{OFS_IRQ_MASK, 32'h0000_0003, 32'hFFFF_FFFF, 32'h0000_0003, RESP_OKAY},
        '{OFS_CTRL_ONE, 32'h0000_00FA, 32'hFFFF_FFFF, 32'h0000_000A, RESP_OKAY},
        '{8'h18, 32'h0000_FFFF, 32'hFFFF_FFFF, 32'h0000_0000, RESP_SLVERR},
        '{OFS_CTRL_TWO, 32'h0000_35C6, 32'hFFFF_F000, 32'h0000_1000, RESP_OKAY},
        '{OFS_CTRL_TWO, 32'h0000_1A7E, 32'hFFFF_F000, 32'h0000_1000, RESP_OKAY}
    };

    always #10 ref_clk = ~ref_clk;

    // count time-out pulses; the output stands one cycle, so every edge is looked at
    always @(posedge ref_clk) begin
        if (wd_timeout === 1'b1) begin
            to_seen <= to_seen + 1;
        end
    end

    wcku_top u_dut (
        .ref_clk(ref_clk), .rst_n(rst_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq), .wd_timeout(wd_timeout)
    );

    // =====================================================================
    // comparison, closing report and bus tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic test_done;
        $display("checks=%0d failures=%0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic hang;
        failures++;
        test_done();
    endtask

    // an edge passes first so a released strobe is never raised in the same step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 64; n++) begin
            @(posedge ref_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                bresp_q = bresp;
                bready <= 1'b0;
                return;
            end
        end
        hang();
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 64; n++) begin
            @(posedge ref_clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                rdata_q = rdata;
                rresp_q = rresp;
                rready <= 1'b0;
                return;
            end
        end
        hang();
    endtask

    // enable with a chosen prescaler mode and code, count cycles to the time-out
    task automatic run_to(input logic pm, input logic [3:0] code, output int cyc);
        int b;
        wr(OFS_CTRL_ONE, {28'h0, code});
        wr(OFS_CTRL_TWO, {16'h0, 2'b01, 1'b0, pm, KEY_FIRST});
        b = to_seen;
        for (cyc = 0; cyc < 2000 && to_seen == b; cyc++) @(posedge ref_clk);
        if (to_seen == b) hang();
    endtask

    // =====================================================================
    // main sequence
    initial begin
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(OFS_CTRL_TWO);
        chk(rdata_q, 32'h0000_1000);
        chk({31'h0, irq}, 32'h0);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            chk({30'h0, bresp_q}, {30'h0, rows[i].r});
            rd(rows[i].a);
            chk({30'h0, rresp_q}, {30'h0, rows[i].r});
            chk(rdata_q & rows[i].m, rows[i].e);
        end
        // completed key pair flags a service and raises the interrupt
        rd(OFS_IRQ_STAT);
        chk(rdata_q, 32'h0000_0002);
        chk({31'h0, irq}, 32'h1);
        wr(OFS_IRQ_STAT, 32'h2);
        rd(OFS_IRQ_MASK);
        chk({31'h0, irq}, 32'h0);
        // wrong key while disabled still times out, flag and interrupt follow
        base = to_seen;
        wr(OFS_CTRL_TWO, 32'h0000_1123);
        rd(OFS_CTRL_TWO);
        chk(rdata_q & 32'hF000, 32'h9000);
        chk(32'(to_seen - base), 32'h1);
        rd(OFS_IRQ_STAT);
        chk(rdata_q, 32'h0000_0001);
        chk({31'h0, irq}, 32'h1);
        wr(OFS_IRQ_MASK, 32'h0);
        rd(OFS_IRQ_STAT);
        chk({31'h0, irq}, 32'h0);
        wr(OFS_IRQ_MASK, 32'h3);
        wr(OFS_IRQ_STAT, 32'h1);
        rd(OFS_IRQ_MASK);
        chk({31'h0, irq}, 32'h0);
        // flag cleared by writing one, then by enabling
        wr(OFS_CTRL_TWO, 32'h0000_95C6);
        rd(OFS_CTRL_TWO);
        chk(rdata_q & 32'hF000, 32'h1000);
        wr(OFS_CTRL_TWO, 32'h0000_1111);
        wr(OFS_CTRL_TWO, 32'h0000_45C6);
        rd(OFS_CTRL_TWO);
        chk(rdata_q & 32'hF000, 32'h4000);
        // prompt servicing keeps the enabled watchdog quiet; enable cannot be written off
        base = to_seen;
        repeat (4) begin
            wr(OFS_CTRL_TWO, 32'h0000_05C6);
            rd(OFS_CTRL_TWO);
            chk(rdata_q & 32'hF000, 32'h4000);
            wr(OFS_CTRL_TWO, 32'h0000_0A7E);
        end
        chk(32'(to_seen - base), 32'h0);
        // second word without the first is a wrong key
        wr(OFS_CTRL_TWO, 32'h0000_0A7E);
        rd(OFS_CTRL_TWO);
        chk(rdata_q & 32'hF000, 32'h8000);
        // disabled: counter frozen and no time-out
        rd(OFS_COUNT);
        p1 = rdata_q;
        base = to_seen;
        repeat (100) @(posedge ref_clk);
        rd(OFS_COUNT);
        chk(rdata_q, p1);
        chk(32'(to_seen - base), 32'h0);
        // time-out intervals: indirect code n must match direct reload 2^(n+1)-1
        wr(OFS_PERIOD, 32'h4);
        run_to(1'b0, 4'h1, c1);
        run_to(1'b1, 4'h0, c2);
        run_to(1'b0, 4'h3, c3);
        run_to(1'b1, 4'h1, c4);
        chk(32'(c2), 32'(c1));
        chk(32'(c4), 32'(c3));
        chk(32'(c3 > c1), 32'h1);
        // direct prescaler is visible while running, indirect one reads 0
        wr(OFS_PERIOD, 32'hFFFF);
        wr(OFS_CTRL_ONE, 32'hF);
        wr(OFS_CTRL_TWO, 32'h0000_45C6);
        rd(OFS_CTRL_ONE);
        p1 = rdata_q;
        rd(OFS_CTRL_ONE);
        chk(32'(p1[7:4] != rdata_q[7:4]), 32'h1);
        wr(OFS_CTRL_TWO, 32'h0000_15C6);
        rd(OFS_CTRL_ONE);
        chk(rdata_q & 32'hF0, 32'h0);
        // reset in mid-run drops enable and restores the register
        rst_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(OFS_CTRL_TWO);
        chk(rdata_q, 32'h0000_1000);
        rd(OFS_CTRL_ONE);
        chk(rdata_q, 32'h0);
        test_done();
    end

endmodule // test_watchdog_control_key_unit

`default_nettype wire
